// ---- bench/fbc_flash_model.sv ----
// Behavioural byte-mode flash that answers the controller's strobes.
// Assumes the pins change only on rising edges of clk.
module fbc_flash_model #(
  parameter logic [7:0] MAKER = 8'h3C, // Arbitrary identity value.
  parameter logic [7:0] PART = 8'hC3 // Arbitrary identity value.
) (
  input wire logic clk,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic [21:0] addr,
  input wire logic [7:0] dq,
  input wire logic dqOe,
  input wire logic fast,
  output logic [7:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] la [0:63];
  logic [7:0] ld [0:63];
  logic lf [0:63];
  int n = 0;
  logic weP = 1'b1;
  logic auto = 1'b0;
  logic [7:0] rv;
  logic [7:0] last = 8'h00;
  always_comb begin
    rv = addr[7:0] ^ 8'h5A;
    if (auto) begin
      case (addr[7:0])
        8'h00: rv = MAKER;
        8'h02: rv = PART;
        8'h04: rv = 8'hFE;
        default: rv = 8'h81;
      endcase
    end
  end
  // A released bus shows the inverse of the last value, never a copy.
  assign dqIn = (!ceN && !oeN) ? rv : ~last;
  // Data is taken when the write strobe rises with the chip selected.
  always @(posedge clk) begin
    weP <= weN;
    if (!ceN && !oeN) last <= rv;
    if (!ceN && weN && !weP && n < 64) begin
      la[n] <= addr;
      ld[n] <= dqOe ? dq : ~dq;
      lf[n] <= fast;
      n <= n + 1;
      if (dq == 8'hF0 || dq == 8'h00) auto <= 1'b0;
      else if (dq == 8'h90 && addr[11:0] == 12'hAAA) auto <= 1'b1;
    end
  end
endmodule

// ---- bench/fbc_host_ctrl_tb.sv ----
// Self-checking bench driving the flash controller over APB.
// Assumes the behavioural flash model on the far side of the pins.
module fbc_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [21:0] UA = 22'h000AAA;
  localparam logic [21:0] UB = 22'h000555;
  localparam logic [21:0] SEC = 22'h018000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, ceN, weN, oeN, dqOe, fastPin, err;
  logic fast = 1'b0;
  logic [21:0] fAddr;
  logic [7:0] dqOut, dqIn;
  int num_errors = 0;
  int n_checks = 0;
  int m = 0;
  fbc_host_ctrl #(.AW(22)) i_fbc_host_ctrl (.clk(clk), .resetn(resetn),
    .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flashCeN(ceN), .flashWeN(weN), .flashOeN(oeN),
    .flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe),
    .flashDqIn(dqIn), .fastProgramPin(fastPin));
  fbc_flash_model #(.MAKER(8'h3C), .PART(8'hC3)) i_fbc_flash_model (
    .clk(clk), .ceN(ceN), .weN(weN), .oeN(oeN), .addr(fAddr),
    .dq(dqOut), .dqOe(dqOe), .fast(fastPin), .dqIn(dqIn));
  initial begin
    forever #20 clk = ~clk;
  end
  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // The answer is taken at the rising edge that shows pready high, and the
  // request is released right after that edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task op(input logic [3:0] o, input logic [21:0] a, input logic [7:0] d);
    m = i_fbc_flash_model.n;
    apb(1'b1, fbc_pkg::REG_ADDR, {10'h0, a});
    apb(1'b1, fbc_pkg::REG_DATA, {24'h0, d});
    apb(1'b1, fbc_pkg::REG_CTRL, {1'b1, 22'h0, fast, 4'h0, o});
    repeat (100) begin
      apb(1'b0, fbc_pkg::REG_STAT, 32'h0);
      if (q[fbc_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    // A sequence that never ends is counted here, not only by the watchdog.
    chk("busy clear", {31'h0, q[fbc_pkg::STAT_BUSY_BIT]}, 32'h0);
  endtask
  task ex(input int k, input logic [21:0] a, input logic [7:0] d);
    chk("flash addr", {10'h0, i_fbc_flash_model.la[m+k]}, {10'h0, a});
    chk("flash data", {24'h0, i_fbc_flash_model.ld[m+k]}, {24'h0, d});
  endtask
  task cnt(input int c);
    chk("write count", 32'(i_fbc_flash_model.n - m), 32'(c));
  endtask
  task ul(input logic [7:0] c);
    ex(0, UA, 8'hAA);
    ex(1, UB, 8'h55);
    ex(2, UA, c);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    chk("idle select", {31'h0, ceN}, 32'h1);
    resetn <= 1'b1;
    apb(1'b0, fbc_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    op(fbc_pkg::OP_READ, 22'h000123, 8'h00);
    cnt(0);
    apb(1'b0, fbc_pkg::REG_RDATA, 32'h0);
    chk("array read", q, {24'h0, 8'h23 ^ 8'h5A});
    op(fbc_pkg::OP_AUTOSEL, 22'h000000, 8'h00);
    ul(8'h90);
    apb(1'b0, fbc_pkg::REG_RDATA, 32'h0);
    chk("maker id", q, 32'h3C);
    op(fbc_pkg::OP_AUTOSEL, 22'h000002, 8'h00);
    apb(1'b0, fbc_pkg::REG_RDATA, 32'h0);
    chk("part id", q, 32'hC3);
    op(fbc_pkg::OP_AUTOSEL, SEC | 22'h4, 8'h00);
    apb(1'b0, fbc_pkg::REG_RDATA, 32'h0);
    chk("protected", {31'h0, q[0]}, 32'h0);
    op(fbc_pkg::OP_RESET, 22'h0, 8'h00);
    cnt(1);
    ex(0, 22'h0, 8'hF0);
    op(fbc_pkg::OP_SECENTER, 22'h0, 8'h00);
    ul(8'h88);
    op(fbc_pkg::OP_EXIT, 22'h0, 8'h00);
    ul(8'h90);
    ex(3, 22'h0, 8'h00);
    op(fbc_pkg::OP_PROGRAM, 22'h3F1234, 8'h5C);
    ul(8'hA0);
    ex(3, 22'h3F1234, 8'h5C);
    op(fbc_pkg::OP_BUFABORT, 22'h0, 8'h00);
    ul(8'hF0);
    cnt(3);
    op(fbc_pkg::OP_SUSPEND, 22'h0, 8'h00);
    cnt(0);
    chk("refused", {31'h0, q[fbc_pkg::STAT_ERR_BIT]}, 32'h1);
    op(fbc_pkg::OP_SECTERASE, SEC, 8'h00);
    ul(8'h80);
    ex(3, UA, 8'hAA);
    ex(5, SEC, 8'h30);
    op(fbc_pkg::OP_SUSPEND, 22'h0, 8'h00);
    ex(0, 22'h0, 8'hB0);
    chk("suspended", {31'h0, q[fbc_pkg::STAT_SUSP_BIT]}, 32'h1);
    op(fbc_pkg::OP_RESUME, 22'h0, 8'h00);
    ex(0, 22'h0, 8'h30);
    cnt(1);
    op(fbc_pkg::OP_RESUME, 22'h0, 8'h00);
    cnt(0);
    chk("no resume", {31'h0, q[fbc_pkg::STAT_ERR_BIT]}, 32'h1);
    op(fbc_pkg::OP_CHIPERASE, 22'h0, 8'h00);
    ex(4, UB, 8'h55);
    ex(5, UA, 8'h10);
    op(fbc_pkg::OP_MODEPROG, SEC, 8'h00);
    cnt(0);
    op(fbc_pkg::OP_MODEENTRY, 22'h0, 8'hC0);
    ul(8'hC0);
    chk("in mode", {31'h0, q[fbc_pkg::STAT_MODE_BIT]}, 32'h1);
    fast = 1'b1;
    op(fbc_pkg::OP_MODEPROG, SEC, 8'h00);
    ex(0, 22'h0, 8'hA0);
    ex(1, SEC, 8'h00);
    chk("fast pin", {31'h0, i_fbc_flash_model.lf[m+1]}, 32'h1);
    fast = 1'b0;
    op(fbc_pkg::OP_PPBERASE, 22'h0, 8'h00);
    ex(0, 22'h0, 8'h80);
    ex(1, 22'h0, 8'h30);
    op(fbc_pkg::OP_EXIT, 22'h0, 8'h00);
    cnt(2);
    op(fbc_pkg::OP_MODEENTRY, 22'h0, 8'h60);
    for (int i = 0; i < 4; i++) begin
      op(fbc_pkg::OP_MODEPROG, 22'(3 - i), 8'h10 + 8'(i));
      ex(1, 22'(3 - i), 8'h10 + 8'(i));
    end
    op(fbc_pkg::OP_EXIT, 22'h0, 8'h00);
    m = i_fbc_flash_model.n - 2;
    ex(0, 22'h0, 8'h90);
    ex(1, 22'h0, 8'h00);
    chk("mode left", {31'h0, q[fbc_pkg::STAT_MODE_BIT]}, 32'h0);
    op(fbc_pkg::OP_RAW, SEC, 8'h29);
    ex(0, SEC, 8'h29);
    cnt(1);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule

// ---- core/fbc_apb_regs.sv ----
// APB slave holding the controller's own command and status registers.
// Assumes a single-clock APB master; every access answers in one cycle.
module fbc_apb_regs #(
  parameter int AW = 22
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] status,
  input wire logic [7:0] lastRead,
  output logic goPulse,
  output logic [3:0] op,
  output logic fastReq,
  output logic [AW-1:0] cmdAddr,
  output logic [7:0] cmdData
);
  logic [31:0] ctrl_q, ctrl_d, addr_q, addr_d, data_q, data_d;
  logic [31:0] rd_d, rdat_q, rdat_d;
  logic go_d, go_q, err_d;
  logic rdy_q, rdy_d, slv_q, slv_d;
  logic acc, setup;

  assign acc = psel && penable;
  // The answer is prepared in the setup cycle and registered, so the bus
  // still sees no wait state while every output comes from a flop.
  assign setup = psel && !penable;

  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    data_d = data_q;
    go_d = 1'b0;
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr)
      fbc_pkg::REG_CTRL: rd_d = ctrl_q;
      fbc_pkg::REG_ADDR: rd_d = addr_q;
      fbc_pkg::REG_DATA: rd_d = data_q;
      fbc_pkg::REG_STAT: rd_d = {27'h0, status};
      fbc_pkg::REG_RDATA: rd_d = {24'h0, lastRead};
      default: err_d = 1'b1;
    endcase
    if (acc && pwrite) begin
      unique case (paddr)
        fbc_pkg::REG_CTRL: begin
          ctrl_d = {1'b0, pwdata[30:0]};
          go_d = pwdata[fbc_pkg::CTRL_GO_BIT];
        end
        fbc_pkg::REG_ADDR: addr_d = pwdata;
        fbc_pkg::REG_DATA: data_d = {24'h0, pwdata[7:0]};
        default: ;
      endcase
    end
    rdat_d = setup ? rd_d : rdat_q;
    rdy_d = setup;
    slv_d = setup && err_d;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      data_q <= 32'h0000_0000;
      go_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      rdy_q <= 1'b0;
      slv_q <= 1'b0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      data_q <= data_d;
      go_q <= go_d;
      rdat_q <= rdat_d;
      rdy_q <= rdy_d;
      slv_q <= slv_d;
    end
  end

  assign prdata = rdat_q;
  assign pready = rdy_q;
  assign pslverr = slv_q;
  assign goPulse = go_q;
  assign op = ctrl_q[fbc_pkg::CTRL_OP_LSB +: 4];
  assign fastReq = ctrl_q[fbc_pkg::CTRL_FAST_BIT];
  assign cmdAddr = addr_q[AW-1:0];
  assign cmdData = data_q[7:0];
endmodule

// ---- core/fbc_bus_cycle.sv ----
// One flash bus cycle: a write strobe or a read with data capture.
// Assumes the flash pins are synchronous to clk.
module fbc_bus_cycle #(
  parameter int AW = 22
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic [AW-1:0] flashAddr,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [7:0] flashDqIn
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_SETUP = 4'b0010, S_PULSE = 4'b0100,
    S_HOLD = 4'b1000
  } fbc_bc_e;
  fbc_bc_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [AW-1:0] a_q, a_d;
  logic [7:0] w_q, w_d, r_q, r_d;
  logic done_q, done_d;
  logic ceN_q, ceN_d, weN_q, weN_d, oeN_q, oeN_d, dqOe_q, dqOe_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    a_d = a_q;
    w_d = w_q;
    r_d = r_q;
    done_d = 1'b0;
    unique case (st_q)
      S_IDLE: if (start) begin
        wr_d = isWrite;
        a_d = addr;
        w_d = wdata;
        cnt_d = 4'(fbc_pkg::SETUP_CYC);
        st_d = S_SETUP;
      end
      S_SETUP: if (cnt_q <= 4'h1) begin
        cnt_d = 4'(fbc_pkg::PULSE_CYC);
        st_d = S_PULSE;
      end else cnt_d = cnt_q - 4'h1;
      S_PULSE: if (cnt_q <= 4'h1) begin
        // Read data is taken just before the strobe rises.
        if (!wr_q) r_d = flashDqIn;
        cnt_d = 4'(fbc_pkg::HOLD_CYC);
        st_d = S_HOLD;
      end else cnt_d = cnt_q - 4'h1;
      S_HOLD: if (cnt_q <= 4'h1) begin
        done_d = 1'b1;
        st_d = S_IDLE;
      end else cnt_d = cnt_q - 4'h1;
    endcase
    // Strobes are decoded from the next state and registered, so the pins
    // come from flops yet keep exactly the timing of the state register.
    ceN_d = (st_d == S_IDLE);
    weN_d = !(wr_d && st_d == S_PULSE);
    oeN_d = !(!wr_d && st_d == S_PULSE);
    dqOe_d = wr_d && (st_d != S_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      a_q <= '0;
      w_q <= 8'h00;
      r_q <= 8'h00;
      done_q <= 1'b0;
      ceN_q <= 1'b1;
      weN_q <= 1'b1;
      oeN_q <= 1'b1;
      dqOe_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      a_q <= a_d;
      w_q <= w_d;
      r_q <= r_d;
      done_q <= done_d;
      ceN_q <= ceN_d;
      weN_q <= weN_d;
      oeN_q <= oeN_d;
      dqOe_q <= dqOe_d;
    end
  end

  // Address is stable through setup and hold, so it is valid at both the
  // falling and the rising strobe edge.
  assign done = done_q;
  assign rdata = r_q;
  assign flashAddr = a_q;
  assign flashDqOut = w_q;
  assign flashDqOe = dqOe_q;
  assign flashCeN = ceN_q;
  assign flashWeN = weN_q;
  assign flashOeN = oeN_q;
endmodule

// ---- core/fbc_host_ctrl.sv ----
// Host controller that issues byte-mode command sequences to a NOR flash.
// Assumes flash pins synchronous to clk and software on APB.
// Notes on behaviour
// - Unlocked commands open with AA at AAA, then 55 at 555, then code.
// - Reset code F0 to any address returns the flash to reading.
// - Secured region: enter with 88; leave with 90 then 00.
// - Buffer abort: unlock pair then F0 at AAA.
// - Every protection mode ends with 90 then 00; OP_RESET here also clears the mode flag after sending F0 alone.
// - Each password piece gets its own A0 then address and value.
// - Password reads drive the full address.
// - Fast-program pin held high while setting protection bits.
// - A buffered write must not pass 37 bus cycles.
// - Unlock-bypass is left with the bypass reset pair.
module fbc_host_ctrl #(
  parameter int AW = 22
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic [AW-1:0] flashAddr,
  output logic [7:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [7:0] flashDqIn,
  output logic fastProgramPin
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_ISSUE = 4'b0010, H_WAIT = 4'b0100,
    H_NEXT = 4'b1000
  } fbc_h_e;

  typedef struct packed {
    logic valid;
    logic isWrite;
    logic [AW-1:0] addr;
    logic [7:0] data;
  } fbc_step_s;

  fbc_h_e st_q, st_d;
  logic [2:0] step_q, step_d;
  logic [3:0] opr_q, opr_d;
  logic mode_q, mode_d, susp_q, susp_d, erase_q, erase_d;
  logic err_q, err_d, fast_q, fast_d;
  logic [AW-1:0] ua_q, ua_d;
  logic [7:0] ud_q, ud_d, last_q, last_d;
  fbc_step_s cur;
  logic goPulse, fastReq, done, bcStart;
  logic [3:0] op;
  logic [AW-1:0] cmdAddr;
  logic [7:0] cmdData, rdata;
  logic [4:0] status;

  // Unlock write number n of a sequence; n is 0 or 1.
  function automatic fbc_step_s unlockStep(input logic n);
    fbc_step_s s;
    s.valid = 1'b1;
    s.isWrite = 1'b1;
    s.addr = n ? AW'(fbc_pkg::UNLOCK_ADDR2) : AW'(fbc_pkg::UNLOCK_ADDR1);
    s.data = n ? fbc_pkg::UNLOCK_DATA2 : fbc_pkg::UNLOCK_DATA1;
    return s;
  endfunction

  function automatic fbc_step_s wr(input logic [AW-1:0] a,
                                   input logic [7:0] d);
    fbc_step_s s;
    s.valid = 1'b1;
    s.isWrite = 1'b1;
    s.addr = a;
    s.data = d;
    return s;
  endfunction

  // Table of sequences; step index walks the bus cycles of one command.
  always_comb begin
    cur = '0;
    unique case (opr_q)
      fbc_pkg::OP_READ: if (step_q == 3'd0) begin
        cur = wr(ua_q, 8'h00);
        cur.isWrite = 1'b0;
      end
      fbc_pkg::OP_RESET: if (step_q == 3'd0)
        cur = wr(AW'(0), fbc_pkg::CMD_RESET);
      fbc_pkg::OP_AUTOSEL: unique case (step_q)
        3'd0, 3'd1: cur = unlockStep(step_q[0]);
        3'd2: cur = wr(AW'(fbc_pkg::UNLOCK_ADDR1), fbc_pkg::CMD_AUTOSEL);
        3'd3: begin
          cur = wr(ua_q, 8'h00);
          cur.isWrite = 1'b0;
        end
        default: ;
      endcase
      fbc_pkg::OP_SECENTER, fbc_pkg::OP_BUFABORT, fbc_pkg::OP_MODEENTRY:
        unique case (step_q)
          3'd0, 3'd1: cur = unlockStep(step_q[0]);
          3'd2: cur = wr(AW'(fbc_pkg::UNLOCK_ADDR1),
            opr_q == fbc_pkg::OP_SECENTER ? fbc_pkg::CMD_SECENTER :
            opr_q == fbc_pkg::OP_BUFABORT ? fbc_pkg::CMD_RESET : ud_q);
          default: ;
        endcase
      // A protection mode is left by the bare pair; the secured region
      // needs the unlock pair in front of it.
      fbc_pkg::OP_EXIT: if (mode_q) begin
        unique case (step_q)
          3'd0: cur = wr(AW'(0), fbc_pkg::CMD_AUTOSEL);
          3'd1: cur = wr(AW'(0), fbc_pkg::CMD_EXITDATA);
          default: ;
        endcase
      end else begin
        unique case (step_q)
          3'd0, 3'd1: cur = unlockStep(step_q[0]);
          3'd2: cur = wr(AW'(fbc_pkg::UNLOCK_ADDR1), fbc_pkg::CMD_AUTOSEL);
          3'd3: cur = wr(AW'(0), fbc_pkg::CMD_EXITDATA);
          default: ;
        endcase
      end
      fbc_pkg::OP_PROGRAM: unique case (step_q)
        3'd0, 3'd1: cur = unlockStep(step_q[0]);
        3'd2: cur = wr(AW'(fbc_pkg::UNLOCK_ADDR1), fbc_pkg::CMD_PROGRAM);
        3'd3: cur = wr(ua_q, ud_q);
        default: ;
      endcase
      fbc_pkg::OP_MODEPROG: unique case (step_q)
        3'd0: cur = wr(AW'(0), fbc_pkg::CMD_PROGRAM);
        3'd1: cur = wr(ua_q, ud_q);
        default: ;
      endcase
      fbc_pkg::OP_PPBERASE: unique case (step_q)
        3'd0: cur = wr(AW'(0), fbc_pkg::CMD_PPBERASE);
        3'd1: cur = wr(AW'(0), fbc_pkg::CMD_PPBERASE2);
        default: ;
      endcase
      fbc_pkg::OP_SUSPEND: if (step_q == 3'd0)
        cur = wr(AW'(0), fbc_pkg::CMD_SUSPEND);
      fbc_pkg::OP_RESUME: if (step_q == 3'd0)
        cur = wr(AW'(0), fbc_pkg::CMD_RESUME);
      fbc_pkg::OP_CHIPERASE, fbc_pkg::OP_SECTERASE:
        unique case (step_q)
          3'd0, 3'd1: cur = unlockStep(step_q[0]);
          3'd2: cur = wr(AW'(fbc_pkg::UNLOCK_ADDR1), fbc_pkg::CMD_ERASE);
          3'd3, 3'd4: cur = unlockStep(~step_q[0]);
          3'd5: cur = (opr_q == fbc_pkg::OP_CHIPERASE) ?
            wr(AW'(fbc_pkg::UNLOCK_ADDR1), fbc_pkg::CMD_CHIPERASE) :
            wr(ua_q, fbc_pkg::CMD_SECTERASE);
          default: ;
        endcase
      // Single raw write lets software walk a buffered write itself, one
      // cycle per order, keeping the total under the limit.
      fbc_pkg::OP_RAW: if (step_q == 3'd0) cur = wr(ua_q, ud_q);
      default: ;
    endcase
  end

  fbc_apb_regs #(.AW(AW)) uRegs (
    .clk(clk),
    .resetn(resetn),
    .ce(clkEn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status(status),
    .lastRead(last_q),
    .goPulse(goPulse),
    .op(op),
    .fastReq(fastReq),
    .cmdAddr(cmdAddr),
    .cmdData(cmdData)
  );

  // An empty step ends the sequence and must not raise a stray strobe.
  assign bcStart = (st_q == H_ISSUE) && cur.valid;

  fbc_bus_cycle #(.AW(AW)) uCycle (
    .clk(clk),
    .resetn(resetn),
    .ce(clkEn),
    .start(bcStart),
    .isWrite(cur.isWrite),
    .addr(cur.addr),
    .wdata(cur.data),
    .done(done),
    .rdata(rdata),
    .flashCeN(flashCeN),
    .flashWeN(flashWeN),
    .flashOeN(flashOeN),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn)
  );

  always_comb begin
    st_d = st_q;
    step_d = step_q;
    opr_d = opr_q;
    ua_d = ua_q;
    ud_d = ud_q;
    mode_d = mode_q;
    susp_d = susp_q;
    erase_d = erase_q;
    err_d = err_q;
    last_d = last_q;
    fast_d = fast_q;
    unique case (st_q)
      H_IDLE: if (goPulse) begin
        st_d = H_ISSUE;
        err_d = 1'b0;
        opr_d = op;
        ua_d = cmdAddr;
        ud_d = cmdData;
        step_d = 3'd0;
        // Mode instructions are refused outside a mode.
        if (((op == fbc_pkg::OP_MODEPROG || op == fbc_pkg::OP_PPBERASE)
             && !mode_q) || (op == fbc_pkg::OP_SUSPEND && !erase_q)
            || (op == fbc_pkg::OP_RESUME && !susp_q)) begin
          err_d = 1'b1;
          st_d = H_IDLE;
        end
        // Fast pin raised for every OP_MODEPROG, or when fastReq asks; not forced for PPB erase.
        fast_d = fastReq || (op == fbc_pkg::OP_MODEPROG);
      end
      H_ISSUE: st_d = cur.valid ? H_WAIT : H_IDLE;
      H_WAIT: if (done) begin
        if (!cur.isWrite) last_d = rdata;
        st_d = H_NEXT;
      end
      H_NEXT: begin
        step_d = step_q + 3'd1;
        st_d = H_ISSUE;
      end
    endcase
    // Mode, suspend and erase flags move only once the whole sequence is out, so that every step
    // of one sequence is decoded in the same mode.
    if (st_q == H_ISSUE && !cur.valid) begin
      fast_d = fastReq;
      unique case (opr_q)
        fbc_pkg::OP_MODEENTRY: mode_d = 1'b1;
        fbc_pkg::OP_EXIT, fbc_pkg::OP_RESET: mode_d = 1'b0;
        fbc_pkg::OP_SECTERASE: erase_d = 1'b1;
        fbc_pkg::OP_SUSPEND: susp_d = 1'b1;
        fbc_pkg::OP_RESUME: susp_d = 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= H_IDLE;
      step_q <= 3'd0;
      opr_q <= 4'h0;
      ua_q <= '0;
      ud_q <= 8'h00;
      mode_q <= 1'b0;
      susp_q <= 1'b0;
      erase_q <= 1'b0;
      err_q <= 1'b0;
      last_q <= 8'h00;
      fast_q <= 1'b0;
    end else if (clkEn) begin
      st_q <= st_d;
      step_q <= step_d;
      opr_q <= opr_d;
      ua_q <= ua_d;
      ud_q <= ud_d;
      mode_q <= mode_d;
      susp_q <= susp_d;
      erase_q <= erase_d;
      err_q <= err_d;
      last_q <= last_d;
      fast_q <= fast_d;
    end
  end

  // Erase state is cleared only by resetn, not by OP_RESET; no status polling here.
  assign status = {err_q, erase_q, susp_q, mode_q, st_q != H_IDLE};
  assign fastProgramPin = fast_q;

  chk_unlock_first: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_ISSUE && step_q == 3'd0 && opr_q == fbc_pkg::OP_PROGRAM)
    |-> cur.addr == AW'(12'hAAA) && cur.data == 8'hAA)
    else $error("first unlock write wrong");
  chk_reset_code: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_ISSUE && opr_q == fbc_pkg::OP_RESET && step_q == 3'd0)
    |-> cur.data == 8'hF0 && cur.isWrite)
    else $error("reset code wrong");
  chk_mode_gate: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_IDLE && goPulse && clkEn && op == fbc_pkg::OP_MODEPROG
     && !mode_q) |=> st_q == H_IDLE && err_q)
    else $error("mode instruction not refused");
  chk_fast_pin: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_WAIT && opr_q == fbc_pkg::OP_MODEPROG) |-> fast_q)
    else $error("fast pin low while setting bits");
  chk_suspend_gate: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_IDLE && goPulse && clkEn && op == fbc_pkg::OP_RESUME
     && !susp_q) |=> err_q)
    else $error("resume not refused");
  chk_autosel_read: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_ISSUE && opr_q == fbc_pkg::OP_AUTOSEL && step_q == 3'd3)
    |-> !cur.isWrite && cur.addr == ua_q)
    else $error("autoselect read wrong");
  chk_erase_six: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_ISSUE && opr_q == fbc_pkg::OP_CHIPERASE && step_q == 3'd5)
    |-> cur.data == 8'h10 && cur.addr == AW'(12'hAAA))
    else $error("chip erase final write wrong");
  chk_exit_pair: assert property (@(posedge clk) disable iff (!resetn)
    (st_q == H_ISSUE && opr_q == fbc_pkg::OP_EXIT && mode_q
     && step_q == 3'd1)
    |-> cur.data == 8'h00 && $past(cur.data, 4) == 8'h90)
    else $error("exit pair wrong");
endmodule

// ---- include/fbc_pkg.sv ----
// Constants shared by the flash command controller and its helpers.
// Assumes a byte-wide parallel flash driven through its strobe pins.
package fbc_pkg;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'hAAA;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h555;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_SECENTER = 8'h88;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIPERASE = 8'h10;
  localparam logic [7:0] CMD_SECTERASE = 8'h30;
  localparam logic [7:0] CMD_BUFLOAD = 8'h25;
  localparam logic [7:0] CMD_BUFCOMMIT = 8'h29;
  localparam logic [7:0] CMD_EXITDATA = 8'h00;
  localparam logic [7:0] CMD_PPBERASE = 8'h80;
  localparam logic [7:0] CMD_PPBERASE2 = 8'h30;
  localparam logic [11:0] ID_MAKER = 12'h000;
  localparam logic [11:0] ID_PART = 12'h002;
  localparam logic [11:0] ID_SECLOCK = 12'h006;
  localparam logic [11:0] ID_PROTECT = 12'h004;
  localparam int MAX_BUF_CYCLES = 37;
  // Operation codes written to the controller command register.
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_AUTOSEL = 4'h2;
  localparam logic [3:0] OP_SECENTER = 4'h3;
  localparam logic [3:0] OP_EXIT = 4'h4;
  localparam logic [3:0] OP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_BUFABORT = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  localparam logic [3:0] OP_CHIPERASE = 4'h9;
  localparam logic [3:0] OP_SECTERASE = 4'hA;
  localparam logic [3:0] OP_MODEENTRY = 4'hB;
  localparam logic [3:0] OP_MODEPROG = 4'hC;
  localparam logic [3:0] OP_PPBERASE = 4'hD;
  localparam logic [3:0] OP_RAW = 4'hE;
  // Register offsets on APB.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 31;
  localparam int CTRL_FAST_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MODE_BIT = 1;
  localparam int STAT_SUSP_BIT = 2;
  localparam int STAT_ERASE_BIT = 3;
  localparam int STAT_ERR_BIT = 4;
  // Bus strobe timing, in ns, turned into 40 ns cycles.
  localparam int CLK_NS = 40;
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 80;
  localparam int HOLD_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
endpackage
